// >>> dv/acqtb_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the acquisition timebase.
module acqtb_tb_top;
	// Short reset period keeps sample periods at a few dozen cycles.
	localparam int P0 = 8;
	logic clk_sys;
	logic rstn;
	acqtb_pkg::acqtb_bus_req_t bus_req;
	logic [31:0] rd_data;
	logic trigger_armed, sync_trigger_pulse, trigger_event_out;
	logic sample_clock_two, sample_clock_two_low, acquisition_run_low, irq;
	logic arm_req, fire_req;
	// Expected read notes: mask in the high word, value in the low word.
	logic [63:0] exp_q[$];
	logic rd_seen = 1'b0;
	logic [31:0] seed;
	int err_total = 0;
	int num_checks = 0;
	int ev_cnt = 0;

	acqtb_top #(.DEF_PERIOD_TICKS(P0)) dut (.clk_sys(clk_sys), .rstn(rstn),
		.bus_req(bus_req), .rd_data(rd_data), .trigger_armed(trigger_armed),
		.sync_trigger_pulse(sync_trigger_pulse),
		.trigger_event_out(trigger_event_out),
		.sample_clock_two(sample_clock_two),
		.sample_clock_two_low(sample_clock_two_low),
		.acquisition_run_low(acquisition_run_low), .irq(irq));

	acqtb_trig_model #(.ARM_LAG(3)) partner (.clk_sys(clk_sys), .rstn(rstn),
		.arm_req(arm_req), .fire_req(fire_req),
		.trigger_armed(trigger_armed),
		.sync_trigger_pulse(sync_trigger_pulse));

	// Random source; a fixed start keeps every run the same.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Range compare for measured values; unknowns never land in range.
	task automatic chk(input logic [31:0] got, input int lo, input int hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	// Masked compare for one read word.
	task automatic chk_rd(input logic [31:0] got, input logic [63:0] e);
		num_checks++;
		if ((got & e[63:32]) !== (e[31:0] & e[63:32])) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, e[31:0]);
		end
	endtask

	// One bus cycle; strobes drop at the edge that takes them.
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		bus_req <= '{w, r, a, d};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		bus_req.rd <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask

	// Notes the expectation, reads, and hands back the word for polling.
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, output logic [31:0] q);
		exp_q.push_back({m, e});
		bus(1'b0, 1'b1, a, 32'h0000_0000);
		@(posedge clk_sys);
		q = rd_data;
	endtask

	// Polls the status word until one bit is set, within a bound.
	task automatic poll(input int b, input int lim);
		logic [31:0] q;
		int i;
		q = 32'h0000_0000;
		for (i = 0; i < lim && q[b] !== 1'b1; i++) begin
			rd(acqtb_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0000, q);
		end
		chk(q[b], 1, 1);
	endtask

	// Waits for a sample clock level; a spent bound is a mismatch.
	task automatic wait_lvl(input logic v);
		int i;
		for (i = 0; i < 400 && sample_clock_two !== v; i++) begin
			@(posedge clk_sys);
		end
		chk(i, 0, 399);
	endtask

	// Watcher: read data stand only in the cycle after the strobe.
	always @(posedge clk_sys) begin
		if (rd_seen) begin
			chk_rd(rd_data, exp_q.pop_front());
		end
		if (trigger_event_out === 1'b1) begin
			ev_cnt++;
		end
		rd_seen <= bus_req.rd;
	end

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// A hang ends the run as a failure.
	initial begin
		#400000;
		err_total++;
		end_sim;
	end

	initial begin
		logic [31:0] q;
		time t0;
		int pl[4];
		int n, k, c, el, i;
		pl = '{3, 1, 12, 8};
		rstn = 1'b0;
		bus_req = '0;
		arm_req = 1'b0;
		fire_req = 1'b0;
		seed = 32'h6a8b_397d;
		repeat (4) @(posedge clk_sys);
		chk({sample_clock_two_low, acquisition_run_low, irq}, 6, 6);
		rstn <= 1'b1;
		rd(acqtb_pkg::ADDR_PERIOD, P0, 32'h000F_FFFF, q);
		rd(acqtb_pkg::ADDR_DELAY, 32'h0000_0000, 32'h0000_FFFF, q);
		rd(acqtb_pkg::ADDR_INT_MASK, 32'h0000_0000, 32'h0000_0003, q);
		rd(8'h24, 32'h0000_0000, 32'hFFFF_FFFF, q);
		wr(acqtb_pkg::ADDR_STATUS, 32'h0000_000F);
		wr(acqtb_pkg::ADDR_COARSE, 32'h0000_00FF);
		rd(acqtb_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_000C, q);
		rd(acqtb_pkg::ADDR_COARSE, 32'h0000_0000, 32'hFFFF_FFFF, q);
		// The long default period must fit the period register.
		wr(acqtb_pkg::ADDR_PERIOD, acqtb_pkg::PERIOD_TICKS_DEF);
		rd(acqtb_pkg::ADDR_PERIOD, acqtb_pkg::PERIOD_TICKS_DEF,
			32'h000F_FFFF, q);
		$display("Test reset_map finished");
		// Period and high time per setting; below two acts as two.
		foreach (pl[j]) begin
			wr(acqtb_pkg::ADDR_PERIOD, pl[j]);
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			t0 = $time;
			wait_lvl(1'b0);
			el = ($time - t0) / 5;
			// Settings below two act as two; five cycles per master tick.
			k = pl[j] < 2 ? 2 : pl[j];
			chk(el, k / 2 * 5, k / 2 * 5);
			wait_lvl(1'b1);
			el = ($time - t0) / 5;
			chk(el, k * 5, k * 5);
		end
		c = 0;
		for (i = 0; i < 20; i++) begin
			rd(acqtb_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0000, q);
			c = c | (q[0] ? 2 : 1);
			// The two sample clock pins must always be opposite.
			chk({sample_clock_two, sample_clock_two_low}, 1, 2);
		end
		chk(c, 3, 3);
		$display("Test sample_clock finished");
		// Latch-only runs with random delay and trigger phase.
		for (int r = 0; r < 3; r++) begin
			seed = xs(seed);
			n = 1 + seed[1:0];
			k = seed[7:3] % 28;
			wr(acqtb_pkg::ADDR_CTRL, 32'h0000_0000);
			// Settings go in before the run starts; in the first run also before the trigger side is armed.
			wr(acqtb_pkg::ADDR_DELAY, n);
			wr(acqtb_pkg::ADDR_CTRL, 32'h0000_0003);
			rd(acqtb_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_000A, q);
			chk(acquisition_run_low, 0, 0);
			arm_req <= 1'b1;
			poll(acqtb_pkg::STAT_ARMED, 20);
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			repeat (k) @(posedge clk_sys);
			wr(acqtb_pkg::ADDR_LATCH, 32'h0000_0000);
			@(posedge clk_sys);
			chk(trigger_event_out, 1, 1);
			t0 = $time;
			poll(acqtb_pkg::STAT_DONE, 200);
			el = ($time - t0) / 5;
			chk(el, 40 * n - k - 8, 40 * n - k + 8);
			c = (38 - k) / 5;
			rd(acqtb_pkg::ADDR_COARSE, 32'h0000_0000, 32'h0000_0000, q);
			chk(q, c - 1, c + 2);
			rd(acqtb_pkg::ADDR_COARSE, q, 32'h000F_FFFF, q);
			rd(acqtb_pkg::ADDR_FINE, 32'h0000_0000, 32'h0000_0000, q);
			chk(q, 0, 5);
			rd(acqtb_pkg::ADDR_INT_STAT, 32'h0000_0003, 32'h0000_0003, q);
			wr(acqtb_pkg::ADDR_INT_STAT, 32'h0000_0003);
			wr(acqtb_pkg::ADDR_LATCH, 32'h0000_0000);
			repeat (3) @(posedge clk_sys);
			chk(ev_cnt, r + 1, r + 1);
			wr(acqtb_pkg::ADDR_CTRL, 32'h0000_0000);
			rd(acqtb_pkg::ADDR_COARSE, 32'h0000_0000, 32'hFFFF_FFFF, q);
			rd(acqtb_pkg::ADDR_FINE, 32'h0000_0000, 32'hFFFF_FFFF, q);
			rd(acqtb_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_000A, q);
			chk(acquisition_run_low, 1, 1);
		end
		$display("Test latch_runs finished");
		// External trigger: ignored while stopped, taken once running.
		wr(acqtb_pkg::ADDR_DELAY, 32'h0000_0001);
		for (i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			fire_req <= 1'b1;
			@(posedge clk_sys);
			fire_req <= 1'b0;
			repeat (4) @(posedge clk_sys);
			chk(ev_cnt, 3 + i, 3 + i);
			wr(acqtb_pkg::ADDR_CTRL, 32'h0000_0001);
			wr(acqtb_pkg::ADDR_LATCH, 32'h0000_0000);
		end
		poll(acqtb_pkg::STAT_DONE, 200);
		$display("Test ext_trigger finished");
		// Sticky status, mask and level output.
		rd(acqtb_pkg::ADDR_INT_STAT, 32'h0000_0003, 32'h0000_0003, q);
		chk(irq, 0, 0);
		wr(acqtb_pkg::ADDR_INT_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1, 1);
		wr(acqtb_pkg::ADDR_INT_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		chk(irq, 0, 0);
		wr(acqtb_pkg::ADDR_INT_MASK, 32'h0000_0003);
		wr(acqtb_pkg::ADDR_INT_STAT, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1, 1);
		rd(acqtb_pkg::ADDR_INT_STAT, 32'h0000_0002, 32'h0000_0003, q);
		wr(acqtb_pkg::ADDR_INT_STAT, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		chk(irq, 0, 0);
		rd(acqtb_pkg::ADDR_INT_STAT, 32'h0000_0000, 32'h0000_0003, q);
		$display("Test interrupts finished");
		end_sim;
	end
endmodule

// >>> dv/acqtb_trig_model.sv
`timescale 1ns/1ps
// Stand-in for the trigger board: arm level and qualified trigger pulses.
module acqtb_trig_model #(
	// Delay line tap; the armed level follows an arm request by ARM_LAG + 1 cycles (1 to 8).
	parameter int ARM_LAG = 3
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic arm_req,
	input wire logic fire_req,
	output logic trigger_armed,
	output logic sync_trigger_pulse
);
	// Delay line, so the host sees arming come late, as real logic would.
	logic [7:0] lag_r;

	// Armed level trails the request; a pulse follows each fire cycle.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lag_r <= 8'h00;
			trigger_armed <= 1'b0;
			sync_trigger_pulse <= 1'b0;
		end else begin
			lag_r <= {lag_r[6:0], arm_req};
			trigger_armed <= lag_r[ARM_LAG-1];
			sync_trigger_pulse <= fire_req;
		end
	end
endmodule

// >>> verilog/acqtb_pkg.sv
// Summary of operation
// - Status word shows sample clock two level.
// - Host programs sample clock two period.
// - Delay counter loads host count, counts down.
// - Delay decrements once per sample clock period.
// - Qualified trigger event starts delay counter.
// - Delay reaching zero sets busy/done to done.
// - Status word shows trigger armed level.
// - Latch-only mode: latch write makes trigger.
// - Trigger event starts coarse interpolator.
// - Coarse counts master ticks until sample rise.
// - Coarse count final whenever done is shown.
// - Stopped run holds coarse interpolator cleared.
// - Stopped run holds fine interpolator cleared.
// - Fine interpolator stops at next master tick.
package acqtb_pkg;

	// System clock and master count clock rates in MHz.
	localparam int CLK_MHZ = 200;
	localparam int MASTER_MHZ = 40;
	// System cycles per master count clock tick.
	localparam int MCLK_DIV = CLK_MHZ / MASTER_MHZ;
	localparam int DIV_W = $clog2(MCLK_DIV);

	// Default sample clock two period in microseconds, and in master ticks.
	localparam int PERIOD_US_DEF = 400;
	localparam int PERIOD_TICKS_DEF = PERIOD_US_DEF * MASTER_MHZ;
	// Shortest period the generator can make, in master ticks.
	localparam int PERIOD_MIN = 2;

	// Widths of the bus and of the counters.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PER_W = 20;
	localparam int DLY_W = 16;
	localparam int FINE_W = 8;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_DELAY = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_LATCH = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_COARSE = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_FINE = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h20;

	// Control register fields.
	localparam int CTRL_RUN = 0;
	localparam int CTRL_LATCH_SRC = 1;
	// Timebase status word fields.
	localparam int STAT_SCLK = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ARMED = 2;
	localparam int STAT_RUN = 3;
	// Interrupt status and mask fields.
	localparam int INT_W = 2;
	localparam int INT_DONE = 0;
	localparam int INT_TRIG = 1;

	// Reset values.
	localparam logic [DLY_W-1:0] DELAY_RST = 16'h0000;
	localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;

	// Acquisition sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARM = 2'b01,
		ST_DELAY = 2'b10,
		ST_DONE = 2'b11
	} acqtb_state_t;

	// One register bus request as the master presents it.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} acqtb_bus_req_t;

	// Layout of the low bits of the timebase status word.
	typedef struct packed {
		logic run;
		logic armed;
		logic done;
		logic sclk;
	} acqtb_status_t;

endpackage

// >>> verilog/acqtb_top.sv
`timescale 1ns/1ps
module acqtb_top #(
	// Sample clock two period after reset, in master ticks.
	parameter int DEF_PERIOD_TICKS = acqtb_pkg::PERIOD_TICKS_DEF
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire acqtb_pkg::acqtb_bus_req_t bus_req,
	output logic [acqtb_pkg::DATA_W-1:0] rd_data,
	input wire logic trigger_armed,
	input wire logic sync_trigger_pulse,
	output logic trigger_event_out,
	output logic sample_clock_two,
	output logic sample_clock_two_low,
	output logic acquisition_run_low,
	output logic irq
);

	localparam int PW = acqtb_pkg::PER_W;
	localparam int DW = acqtb_pkg::DLY_W;
	localparam int FW = acqtb_pkg::FINE_W;

	// Refuse a default period that the period register cannot hold.
	if (DEF_PERIOD_TICKS < acqtb_pkg::PERIOD_MIN ||
	    DEF_PERIOD_TICKS >= (1 << PW)) begin : g_chk
		$error("DEF_PERIOD_TICKS out of range");
	end

	// Software-visible control state.
	logic ctrl_run_r;
	logic ctrl_latch_r;
	logic [PW-1:0] period_r;
	logic [DW-1:0] delay_r;
	logic [acqtb_pkg::INT_W-1:0] int_stat_r;
	logic [acqtb_pkg::INT_W-1:0] int_mask_r;

	// Timebase state.
	logic [acqtb_pkg::DIV_W-1:0] div_r;
	logic mtick_r;
	logic [PW-1:0] sc_cnt_r;
	logic sc_lvl_r;
	logic sc_rise_r;
	logic run_prev_r;
	acqtb_pkg::acqtb_state_t state_r;
	logic [DW-1:0] dcnt_r;
	logic done_r;
	logic [PW-1:0] coarse_r;
	logic coarse_on_r;
	logic [FW-1:0] fine_r;
	logic fine_on_r;

	// Decoded strobes and events.
	logic latch_wr;
	logic run_start;
	logic trig_ev;
	logic done_set;
	logic [PW-1:0] period_eff;
	logic [PW-1:0] sc_cnt_nxt;
	logic [acqtb_pkg::DATA_W-1:0] rd_nxt;
	acqtb_pkg::acqtb_status_t stat;

	assign latch_wr = bus_req.wr && bus_req.addr == acqtb_pkg::ADDR_LATCH;
	assign run_start = ctrl_run_r && !run_prev_r;
	// Only one trigger per run is taken; later ones find the sequencer in ST_DELAY or ST_DONE.
	// qualified trigger select
	// The run bit is tested as well, so a stop written in the cycle before
	// a trigger refuses it instead of loading a sequencer that is leaving.
	assign trig_ev = ctrl_run_r && state_r == acqtb_pkg::ST_ARM &&
	                 trigger_armed &&
	                 (ctrl_latch_r ? latch_wr : sync_trigger_pulse);
	// Done waits for the coarse count to settle so a read after done is final.
	// done condition
	assign done_set = state_r == acqtb_pkg::ST_DELAY && dcnt_r == '0 &&
	                  !coarse_on_r;

	// Control registers written by the host.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_run_r <= 1'b0;
			ctrl_latch_r <= 1'b0;
			period_r <= PW'(DEF_PERIOD_TICKS);
			delay_r <= acqtb_pkg::DELAY_RST;
			int_mask_r <= acqtb_pkg::INT_MASK_RST;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				acqtb_pkg::ADDR_CTRL: begin
					ctrl_run_r <= bus_req.wdata[acqtb_pkg::CTRL_RUN];
					ctrl_latch_r <= bus_req.wdata[acqtb_pkg::CTRL_LATCH_SRC];
				end
				acqtb_pkg::ADDR_PERIOD: begin
					period_r <= bus_req.wdata[PW-1:0];
				end
				acqtb_pkg::ADDR_DELAY: begin
					delay_r <= bus_req.wdata[DW-1:0];
				end
				acqtb_pkg::ADDR_INT_MASK: begin
					int_mask_r <= bus_req.wdata[acqtb_pkg::INT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Master count clock: a one-cycle tick every MCLK_DIV system cycles.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_r <= '0;
			mtick_r <= 1'b0;
		end else if (div_r == acqtb_pkg::DIV_W'(acqtb_pkg::MCLK_DIV - 1)) begin
			div_r <= '0;
			mtick_r <= 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
			mtick_r <= 1'b0;
		end
	end

	// Periods below the minimum would leave no high phase, so they are raised.
	assign period_eff = (period_r < PW'(acqtb_pkg::PERIOD_MIN)) ?
	                    PW'(acqtb_pkg::PERIOD_MIN) : period_r;
	assign sc_cnt_nxt = (sc_cnt_r >= period_eff - 1'b1) ? '0 :
	                    sc_cnt_r + 1'b1;

	// Sample clock two runs free so the host can poll it even when stopped;
	// it is high for the first period/2 master ticks of each period, rounded down.
	// sample clock generator
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sc_cnt_r <= '0;
			sc_lvl_r <= 1'b0;
			sc_rise_r <= 1'b0;
		end else if (mtick_r) begin
			sc_cnt_r <= sc_cnt_nxt;
			sc_lvl_r <= sc_cnt_nxt < (period_eff >> 1);
			sc_rise_r <= sc_cnt_nxt == '0;
		end else begin
			sc_rise_r <= 1'b0;
		end
	end

	// Run edge detector.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			run_prev_r <= 1'b0;
		end else begin
			run_prev_r <= ctrl_run_r;
		end
	end

	// Acquisition sequencer; stopping the run returns it to idle at once.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= acqtb_pkg::ST_IDLE;
		end else if (!ctrl_run_r) begin
			state_r <= acqtb_pkg::ST_IDLE;
		end else begin
			case (state_r)
				acqtb_pkg::ST_IDLE: begin
					if (run_start) begin
						state_r <= acqtb_pkg::ST_ARM;
					end
				end
				acqtb_pkg::ST_ARM: begin
					if (trig_ev) begin
						state_r <= acqtb_pkg::ST_DELAY;
					end
				end
				acqtb_pkg::ST_DELAY: begin
					if (done_set) begin
						state_r <= acqtb_pkg::ST_DONE;
					end
				end
				acqtb_pkg::ST_DONE: begin
				end
				default: begin
					state_r <= acqtb_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Post-trigger delay counter, loaded on the trigger event.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dcnt_r <= '0;
		end else if (trig_ev) begin
			dcnt_r <= delay_r;
		end else if (state_r == acqtb_pkg::ST_DELAY && sc_rise_r &&
		             dcnt_r != '0) begin
			dcnt_r <= dcnt_r - 1'b1;
		end
	end

	// Busy/done flag: busy from each run start until the delay ends.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			done_r <= 1'b0;
		end else if (run_start) begin
			done_r <= 1'b0;
		end else if (done_set) begin
			done_r <= 1'b1;
		end
	end

	// Coarse interpolator: master ticks from trigger to next sample rise.
	// The rise pulse lags a tick by one cycle, so the two never coincide.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			coarse_r <= '0;
			coarse_on_r <= 1'b0;
		end else if (!ctrl_run_r) begin
			coarse_r <= '0;
			coarse_on_r <= 1'b0;
		end else if (trig_ev) begin
			coarse_r <= '0;
			coarse_on_r <= 1'b1;
		end else if (coarse_on_r) begin
			if (sc_rise_r) begin
				coarse_on_r <= 1'b0;
			end else if (mtick_r) begin
				coarse_r <= coarse_r + 1'b1;
			end
		end
	end

	// Fine interpolator: system cycles from trigger to next master tick.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fine_r <= '0;
			fine_on_r <= 1'b0;
		end else if (!ctrl_run_r) begin
			fine_r <= '0;
			fine_on_r <= 1'b0;
		end else if (trig_ev) begin
			fine_r <= '0;
			fine_on_r <= 1'b1;
		end else if (fine_on_r) begin
			if (mtick_r) begin
				fine_on_r <= 1'b0;
			end else begin
				fine_r <= fine_r + 1'b1;
			end
		end
	end

	// Sticky interrupt status; a new event wins over a same-cycle clear.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			int_stat_r <= '0;
		end else begin
			for (int i = 0; i < acqtb_pkg::INT_W; i++) begin
				if ((i == acqtb_pkg::INT_DONE && done_set) ||
				    (i == acqtb_pkg::INT_TRIG && trig_ev)) begin
					int_stat_r[i] <= 1'b1;
				end else if (bus_req.wr &&
				             bus_req.addr == acqtb_pkg::ADDR_INT_STAT &&
				             bus_req.wdata[i]) begin
					int_stat_r[i] <= 1'b0;
				end
			end
		end
	end

	// Status word as the host sees it.
	// status bits
	assign stat = '{run: ctrl_run_r, armed: trigger_armed, done: done_r,
	                sclk: sc_lvl_r};

	// Read mux; unmapped addresses and idle cycles read as zero.
	always_comb begin
		rd_nxt = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				acqtb_pkg::ADDR_CTRL: begin
					rd_nxt[acqtb_pkg::CTRL_RUN] = ctrl_run_r;
					rd_nxt[acqtb_pkg::CTRL_LATCH_SRC] = ctrl_latch_r;
				end
				acqtb_pkg::ADDR_PERIOD: rd_nxt[PW-1:0] = period_r;
				acqtb_pkg::ADDR_DELAY: rd_nxt[DW-1:0] = delay_r;
				acqtb_pkg::ADDR_STATUS: rd_nxt[3:0] = stat;
				acqtb_pkg::ADDR_COARSE: rd_nxt[PW-1:0] = coarse_r;
				acqtb_pkg::ADDR_FINE: rd_nxt[FW-1:0] = fine_r;
				acqtb_pkg::ADDR_INT_STAT: rd_nxt[1:0] = int_stat_r;
				acqtb_pkg::ADDR_INT_MASK: rd_nxt[1:0] = int_mask_r;
				default: rd_nxt = '0;
			endcase
		end
	end

	// Registered outputs.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_data <= '0;
			trigger_event_out <= 1'b0;
			sample_clock_two <= 1'b0;
			sample_clock_two_low <= 1'b1;
			acquisition_run_low <= 1'b1;
			irq <= 1'b0;
		end else begin
			rd_data <= rd_nxt;
			trigger_event_out <= trig_ev;
			sample_clock_two <= sc_lvl_r;
			sample_clock_two_low <= !sc_lvl_r;
			acquisition_run_low <= !ctrl_run_r;
			irq <= |(int_stat_r & int_mask_r);
		end
	end

	// Checks on the behaviour above.
	property p_sclk_status;
		@(posedge clk_sys) disable iff (!rstn)
		bus_req.rd && bus_req.addr == acqtb_pkg::ADDR_STATUS |=>
		rd_data[acqtb_pkg::STAT_SCLK] == $past(sc_lvl_r);
	endproperty
	a_sclk_status: assert property (p_sclk_status)
		else $error("sclk bit wrong");

	property p_period_wrap;
		@(posedge clk_sys) disable iff (!rstn)
		mtick_r && sc_cnt_r >= period_eff - 1'b1 |=> sc_rise_r ##1 !sc_rise_r;
	endproperty
	a_period_wrap: assert property (p_period_wrap)
		else $error("no rise at wrap");

	property p_load;
		@(posedge clk_sys) disable iff (!rstn)
		trig_ev |=> dcnt_r == $past(delay_r) &&
		state_r == acqtb_pkg::ST_DELAY;
	endproperty
	a_load: assert property (p_load)
		else $error("delay not loaded");

	property p_dec;
		@(posedge clk_sys) disable iff (!rstn)
		ctrl_run_r && state_r == acqtb_pkg::ST_DELAY && sc_rise_r &&
		dcnt_r != '0 |=> dcnt_r == $past(dcnt_r) - 1'b1;
	endproperty
	a_dec: assert property (p_dec)
		else $error("delay step wrong");

	property p_done;
		@(posedge clk_sys) disable iff (!rstn)
		done_set && ctrl_run_r |=> done_r && state_r == acqtb_pkg::ST_DONE;
	endproperty
	a_done: assert property (p_done)
		else $error("done not set");

	property p_armed;
		@(posedge clk_sys) disable iff (!rstn)
		bus_req.rd && bus_req.addr == acqtb_pkg::ADDR_STATUS |=>
		rd_data[acqtb_pkg::STAT_ARMED] == $past(trigger_armed);
	endproperty
	a_armed: assert property (p_armed)
		else $error("armed bit wrong");

	property p_latch;
		@(posedge clk_sys) disable iff (!rstn)
		state_r == acqtb_pkg::ST_ARM && ctrl_run_r && ctrl_latch_r &&
		trigger_armed && latch_wr |=> trigger_event_out;
	endproperty
	a_latch: assert property (p_latch)
		else $error("latch no trigger");

	property p_coarse_start;
		@(posedge clk_sys) disable iff (!rstn)
		trig_ev && ctrl_run_r |=> coarse_on_r && coarse_r == '0;
	endproperty
	a_coarse_start: assert property (p_coarse_start)
		else $error("no start");

	property p_coarse_stop;
		@(posedge clk_sys) disable iff (!rstn)
		ctrl_run_r && coarse_on_r && sc_rise_r |=>
		!coarse_on_r && $stable(coarse_r);
	endproperty
	a_coarse_stop: assert property (p_coarse_stop)
		else $error("no stop");

	property p_final;
		@(posedge clk_sys) disable iff (!rstn)
		done_r |-> !coarse_on_r;
	endproperty
	a_final: assert property (p_final)
		else $error("coarse not final");

	property p_stop_clear;
		@(posedge clk_sys) disable iff (!rstn)
		!ctrl_run_r |=> coarse_r == '0 && fine_r == '0;
	endproperty
	a_stop_clear: assert property (p_stop_clear)
		else $error("not clear");

	property p_fine_stop;
		@(posedge clk_sys) disable iff (!rstn)
		fine_on_r && mtick_r |=> !fine_on_r [*2];
	endproperty
	a_fine_stop: assert property (p_fine_stop)
		else $error("fine runs on");

	property p_busy;
		@(posedge clk_sys) disable iff (!rstn)
		run_start |=> !done_r && state_r == acqtb_pkg::ST_ARM;
	endproperty
	a_busy: assert property (p_busy)
		else $error("not busy at start");

	property p_cov_trig;
		@(posedge clk_sys) disable iff (!rstn) trig_ev && ctrl_latch_r;
	endproperty
	c_trig: cover property (p_cov_trig);

	property p_cov_done;
		@(posedge clk_sys) disable iff (!rstn) done_set ##1 irq [*2];
	endproperty
	c_done: cover property (p_cov_done);

	property p_cov_stop;
		@(posedge clk_sys) disable iff (!rstn)
		state_r == acqtb_pkg::ST_DELAY ##1 !ctrl_run_r;
	endproperty
	c_stop: cover property (p_cov_stop);

endmodule
